/* core/sah_defines.svh */
// Purpose: Offsets, field positions, reset values and timing of the alarm handler
// Assumes: Included by every design file of the alarm handler except the package
// Notes: Byte addresses on an 8-bit register port, one 32-bit word per register
`ifndef SAH_DEFINES_SVH
`define SAH_DEFINES_SVH

// ============================================================
// Register offsets
`define SAH_ADDR_CTRL 8'h00
`define SAH_ADDR_CMD 8'h04
`define SAH_ADDR_STATUS 8'h08
`define SAH_ADDR_INT_STAT 8'h0C
`define SAH_ADDR_INT_MASK 8'h10
`define SAH_ADDR_HIST_CNT 8'h14
`define SAH_ADDR_HIST_BASE 8'h20

// ============================================================
// Field positions
`define SAH_CTRL_CODE_EN 0
`define SAH_CTRL_POS_MODE 1
`define SAH_CMD_RESET 0
`define SAH_CMD_HIST_CLR 1
`define SAH_CMD_ABS_ARM 2
`define SAH_INT_RAISED 0
`define SAH_INT_CLEARED 1
`define SAH_INT_W 2

// ============================================================
// Reset values
`define SAH_CTRL_RESET 2'h0
`define SAH_INT_MASK_RESET 2'h0

// ============================================================
// Sizes and timing
`define SAH_HIST_DEPTH 10
`define SAH_CLK_MHZ 100
`define SAH_TICK_US 1000
`define SAH_TICK_CYCLES (`SAH_CLK_MHZ * `SAH_TICK_US)
`define SAH_BLINK_ON_MS 200
`define SAH_BLINK_OFF_MS 300
`define SAH_BLINK_GAP_MS 1500

`endif

/* core/sah_pkg.sv */
// Purpose: Shared types of the alarm handler
// Assumes: Widths fixed here are checked against module parameters
// Notes: The blinker and the core keep their whole state in one of these structs; the history uses its own
package sah_pkg;

   typedef enum logic [1:0] {BLK_IDLE, BLK_ON, BLK_OFF, BLK_GAP} sah_blink_phase_t;

   typedef struct packed {
      sah_blink_phase_t phase;
      logic [15:0] ticks;
      logic [2:0] left;
      logic led;
   } sah_blink_state_t;

   typedef struct packed {
      logic [23:0] div_cnt;
      logic tick;
      logic mf_prev;
      logic code_en;
      logic pos_mode;
      logic active;
      logic resettable;
      logic abs_loss;
      logic abs_armed;
      logic cuts;
      logic [7:0] code;
      logic [2:0] blinks;
      logic [1:0] int_stat;
      logic [1:0] int_mask;
      logic [31:0] rdata;
      logic ready;
      logic limit;
      logic zero_near;
      logic pos_clk;
   } sah_core_state_t;

endpackage

/* core/sah_blinker.sv */
// Purpose: Alarm LED burst generator, N blinks then a long gap
// Assumes: tick_in is a one-cycle pulse at the tick rate
// Notes: Burst restarts cleanly whenever active_in drops
`timescale 1ns/1ps
`include "sah_defines.svh"
module sah_blinker import sah_pkg::*; #(
   parameter int ON_TICKS = `SAH_BLINK_ON_MS,
   parameter int OFF_TICKS = `SAH_BLINK_OFF_MS,
   parameter int GAP_TICKS = `SAH_BLINK_GAP_MS
) (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic srst_in,
   // Control
   input wire logic tick_in,
   input wire logic active_in,
   input wire logic [2:0] count_in,
   // LED
   output logic led_out
);
   if (ON_TICKS < 1 || OFF_TICKS < 1 || GAP_TICKS < 1 || ON_TICKS > 65535 || OFF_TICKS > 65535 ||
       GAP_TICKS > 65535) begin : g_chk
      $error("sah_blinker: phase lengths must be 1..65535 ticks");
   end

   localparam logic [15:0] ON_LAST = 16'(ON_TICKS - 1);
   localparam logic [15:0] OFF_LAST = 16'(OFF_TICKS - 1);
   localparam logic [15:0] GAP_LAST = 16'(GAP_TICKS - 1);

   sah_blink_state_t s;
   sah_blink_state_t next_s;

   always_comb begin
      next_s = s;
      if (!active_in || count_in == 3'h0) begin
         next_s.phase = BLK_IDLE;
         next_s.led = 1'b0;
      end else begin
         case (s.phase)
            BLK_IDLE: begin
               next_s.phase = BLK_ON;
               next_s.ticks = 16'h0000;
               next_s.left = count_in;
               next_s.led = 1'b1;
            end
            BLK_ON: begin
               if (tick_in) begin
                  next_s.ticks = s.ticks + 16'h0001;
                  if (s.ticks == ON_LAST) begin
                     next_s.ticks = 16'h0000;
                     next_s.led = 1'b0;
                     next_s.left = s.left - 3'h1;
                     next_s.phase = (s.left == 3'h1) ? BLK_GAP : BLK_OFF;
                  end
               end
            end
            BLK_OFF: begin
               if (tick_in) begin
                  next_s.ticks = s.ticks + 16'h0001;
                  if (s.ticks == OFF_LAST) begin
                     next_s.ticks = 16'h0000;
                     next_s.led = 1'b1;
                     next_s.phase = BLK_ON;
                  end
               end
            end
            BLK_GAP: begin
               if (tick_in) begin
                  next_s.ticks = s.ticks + 16'h0001;
                  if (s.ticks == GAP_LAST) begin
                     next_s.phase = BLK_IDLE;
                  end
               end
            end
            default: next_s.phase = BLK_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign led_out = s.led;

   AST_BLINK_DARK: assert property (@(posedge core_clk_in) disable iff (srst_in)
      !active_in |=> !led_out)
      else $error("LED lit with no alarm");
endmodule

/* core/sah_history.sv */
// Purpose: Record of the most recent alarm codes, newest in slot 0
// Assumes: At most one push per cycle
// Notes: A clear in the same cycle as a push keeps only the pushed code
`timescale 1ns/1ps
`include "sah_defines.svh"
module sah_history import sah_pkg::*; #(
   parameter int DEPTH = `SAH_HIST_DEPTH
) (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic srst_in,
   // Update
   input wire logic push_in,
   input wire logic [7:0] push_code_in,
   input wire logic clear_in,
   // Readout
   input wire logic [3:0] rd_index_in,
   output logic [7:0] rd_code_out,
   output logic [3:0] count_out
);
   if (DEPTH < 1 || DEPTH > 15) begin : g_chk
      $error("sah_history: DEPTH must be 1..15");
   end

   typedef struct packed {
      logic [DEPTH-1:0][7:0] slot;
      logic [3:0] count;
   } sah_hist_state_t;

   localparam logic [3:0] FULL = 4'(DEPTH);

   sah_hist_state_t s;
   sah_hist_state_t next_s;

   always_comb begin
      next_s = s;
      if (clear_in) begin
         next_s = '0;
      end
      if (push_in) begin
         for (int i = DEPTH - 1; i > 0; i--) begin
            next_s.slot[i] = clear_in ? 8'h00 : s.slot[i-1];
         end
         next_s.slot[0] = push_code_in;
         next_s.count = (clear_in || s.count == 4'h0) ? 4'h1 : ((s.count == FULL) ? FULL : s.count + 4'h1);
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign rd_code_out = (rd_index_in < FULL) ? s.slot[rd_index_in] : 8'h00;
   assign count_out = s.count;

   AST_HIST_WIPE: assert property (@(posedge core_clk_in) disable iff (srst_in)
      clear_in && !push_in |=> count_out == 4'h0 && s.slot[0] == 8'h00)
      else $error("History not erased");
   AST_HIST_NEWEST: assert property (@(posedge core_clk_in) disable iff (srst_in)
      push_in |=> s.slot[0] == $past(push_code_in) && count_out != 4'h0)
      else $error("Newest alarm not in slot 0");
endmodule

/* core/sah_alarm_handler.sv */
// Purpose: Alarm latch, fault output, shared code outputs, LED bursts, history and resets
// Assumes: All inputs synchronous to core_clk_in; power cycling is srst_in
// Notes: Register port answers every read on the next cycle, never stalls
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "sah_defines.svh"

// What this block does
// - Alarm turns fault output off, stops motor
// - Code enable routes code onto three outputs
// - Position request in position mode wins
// - Code bits suppressed while position readout wins
// - Shared input is readout clock, reset ignored
// - LED blinks alarm-specific count per burst
// - Keep ten latest alarms, newest first
// - Clear-history command erases all entries
// - Reset input clears on falling edge only
// - Setup command and power cycle also clear
// - Non-resettable alarms need a power cycle
// - Position-loss alarm needs extra arming step
// - Current-cutting alarms engage the brake
// - Code bits carry the blink count
module sah_alarm_handler import sah_pkg::*; #(
   parameter int TICK_CYCLES = `SAH_TICK_CYCLES,
   parameter int HIST_DEPTH = `SAH_HIST_DEPTH,
   parameter int BLINK_ON_TICKS = `SAH_BLINK_ON_MS,
   parameter int BLINK_OFF_TICKS = `SAH_BLINK_OFF_MS,
   parameter int BLINK_GAP_TICKS = `SAH_BLINK_GAP_MS
) (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic srst_in,
   // Register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   // Protective condition detectors
   input wire logic alarm_set_in,
   input wire logic [7:0] alarm_code_in,
   input wire logic [2:0] alarm_blinks_in,
   input wire logic alarm_resettable_in,
   input wire logic alarm_abs_loss_in,
   input wire logic alarm_cuts_current_in,
   // Discrete inputs
   input wire logic position_request_in,
   input wire logic shared_multifunction_in,
   input wire logic ready_in,
   input wire logic limit_in,
   input wire logic zero_near_in,
   input wire logic brake_fitted_in,
   // Discrete outputs
   output logic fault_indicator_out,
   output logic motor_stop_out,
   output logic brake_engage_out,
   output logic ready_out,
   output logic limit_reached_out,
   output logic zero_near_out,
   output logic position_readout_clock_out,
   output logic alarm_led_out,
   output logic irq_out
);
   // ============================================================
   // Parameter checks
   if (TICK_CYCLES < 1 || TICK_CYCLES > 16777215) begin : g_chk_tick
      $error("sah_alarm_handler: TICK_CYCLES must be 1..16777215");
   end
   if (HIST_DEPTH != `SAH_HIST_DEPTH) begin : g_chk_hist
      $error("sah_alarm_handler: HIST_DEPTH must match the history window");
   end

   localparam logic [23:0] DIV_LAST = 24'(TICK_CYCLES - 1);
   localparam logic [7:0] HIST_LAST = 8'(`SAH_ADDR_HIST_BASE + 4 * (HIST_DEPTH - 1));

   // ============================================================
   // Helpers
   function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] offset);
      return addr == offset;
   endfunction

   function automatic logic [3:0] hist_slot(input logic [7:0] addr);
      logic [7:0] rel;
      rel = addr - `SAH_ADDR_HIST_BASE;
      return rel[5:2];
   endfunction

   sah_core_state_t s;
   sah_core_state_t next_s;

   logic prio;
   logic mf_fall;
   logic mf_rise;
   logic cmd_wr;
   logic cmd_reset;
   logic hist_clear;
   logic abs_arm;
   logic clear_ok;
   logic alarm_take;
   logic code_route;
   logic [2:0] code_bits;
   logic [3:0] hist_index;
   logic [7:0] hist_code;
   logic [3:0] hist_count;
   logic [1:0] int_events;

   // ============================================================
   // Event decode
   assign prio = s.pos_mode & position_request_in;
   assign mf_fall = s.mf_prev & ~shared_multifunction_in & ~prio;
   assign mf_rise = ~s.mf_prev & shared_multifunction_in;
   assign cmd_wr = reg_wr_in & reg_hit(reg_addr_in, `SAH_ADDR_CMD);
   assign cmd_reset = cmd_wr & reg_wdata_in[`SAH_CMD_RESET];
   assign hist_clear = cmd_wr & reg_wdata_in[`SAH_CMD_HIST_CLR];
   assign abs_arm = cmd_wr & reg_wdata_in[`SAH_CMD_ABS_ARM];
   // Non-resettable alarms ignore both reset sources; position loss also needs arming
   assign clear_ok = s.active & s.resettable & (mf_fall | cmd_reset) & (~s.abs_loss | s.abs_armed);
   // First alarm is kept so the reported code does not shift under the host
   assign alarm_take = alarm_set_in & (~s.active | clear_ok);
   assign code_route = s.code_en & ~prio;
   assign code_bits = s.active ? s.blinks : 3'h0;
   assign int_events = {clear_ok, alarm_take};
   assign hist_index = hist_slot(reg_addr_in);

   // ============================================================
   // Next state
   always_comb begin
      next_s = s;
      next_s.rdata = 32'h0000_0000;
      next_s.mf_prev = shared_multifunction_in;

      if (s.div_cnt == DIV_LAST) begin
         next_s.div_cnt = 24'h00_0000;
         next_s.tick = 1'b1;
      end else begin
         next_s.div_cnt = s.div_cnt + 24'h00_0001;
         next_s.tick = 1'b0;
      end

      if (abs_arm && s.active && s.abs_loss) begin
         next_s.abs_armed = 1'b1;
      end
      if (clear_ok) begin
         next_s.active = 1'b0;
         next_s.abs_armed = 1'b0;
      end
      if (alarm_take) begin
         next_s.active = 1'b1;
         next_s.code = alarm_code_in;
         next_s.blinks = alarm_blinks_in;
         next_s.resettable = alarm_resettable_in;
         next_s.abs_loss = alarm_abs_loss_in;
         next_s.cuts = alarm_cuts_current_in;
         next_s.abs_armed = 1'b0;
      end

      // Status bits: a new event beats a same-cycle write-one clear
      next_s.int_stat = s.int_stat;
      if (reg_wr_in && reg_hit(reg_addr_in, `SAH_ADDR_INT_STAT)) begin
         next_s.int_stat = s.int_stat & ~reg_wdata_in[`SAH_INT_W-1:0];
      end
      next_s.int_stat = next_s.int_stat | int_events;

      if (reg_wr_in && reg_hit(reg_addr_in, `SAH_ADDR_CTRL)) begin
         next_s.code_en = reg_wdata_in[`SAH_CTRL_CODE_EN];
         next_s.pos_mode = reg_wdata_in[`SAH_CTRL_POS_MODE];
      end
      if (reg_wr_in && reg_hit(reg_addr_in, `SAH_ADDR_INT_MASK)) begin
         next_s.int_mask = reg_wdata_in[`SAH_INT_W-1:0];
      end

      if (reg_rd_in) begin
         if (reg_hit(reg_addr_in, `SAH_ADDR_CTRL)) begin
            next_s.rdata[`SAH_CTRL_CODE_EN] = s.code_en;
            next_s.rdata[`SAH_CTRL_POS_MODE] = s.pos_mode;
         end else if (reg_hit(reg_addr_in, `SAH_ADDR_STATUS)) begin
            next_s.rdata[0] = s.active;
            next_s.rdata[1] = s.resettable;
            next_s.rdata[2] = s.abs_loss;
            next_s.rdata[3] = s.abs_armed;
            next_s.rdata[4] = s.cuts;
            next_s.rdata[5] = prio;
            next_s.rdata[10:8] = s.blinks;
            next_s.rdata[23:16] = s.code;
         end else if (reg_hit(reg_addr_in, `SAH_ADDR_INT_STAT)) begin
            next_s.rdata[`SAH_INT_W-1:0] = s.int_stat;
         end else if (reg_hit(reg_addr_in, `SAH_ADDR_INT_MASK)) begin
            next_s.rdata[`SAH_INT_W-1:0] = s.int_mask;
         end else if (reg_hit(reg_addr_in, `SAH_ADDR_HIST_CNT)) begin
            next_s.rdata[3:0] = hist_count;
         end else if (reg_addr_in >= `SAH_ADDR_HIST_BASE && reg_addr_in <= HIST_LAST &&
                      reg_addr_in[1:0] == 2'b00) begin
            next_s.rdata[7:0] = hist_code;
         end
      end

      // Shared outputs registered so they never glitch on an input change
      next_s.ready = code_route ? code_bits[0] : ready_in;
      next_s.limit = code_route ? code_bits[1] : limit_in;
      next_s.zero_near = code_route ? code_bits[2] : zero_near_in;
      next_s.pos_clk = prio & shared_multifunction_in;
   end

   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         s <= '0;
         s.code_en <= 1'(`SAH_CTRL_RESET >> `SAH_CTRL_CODE_EN);
         s.pos_mode <= 1'(`SAH_CTRL_RESET >> `SAH_CTRL_POS_MODE);
         s.int_mask <= `SAH_INT_MASK_RESET;
      end else begin
         s <= next_s;
      end
   end

   // ============================================================
   // Submodules
   sah_history #(
      .DEPTH(HIST_DEPTH)
   ) u_history (
      .core_clk_in(core_clk_in),
      .srst_in(srst_in),
      .push_in(alarm_take),
      .push_code_in(alarm_code_in),
      .clear_in(hist_clear),
      .rd_index_in(hist_index),
      .rd_code_out(hist_code),
      .count_out(hist_count)
   );

   sah_blinker #(
      .ON_TICKS(BLINK_ON_TICKS),
      .OFF_TICKS(BLINK_OFF_TICKS),
      .GAP_TICKS(BLINK_GAP_TICKS)
   ) u_blinker (
      .core_clk_in(core_clk_in),
      .srst_in(srst_in),
      .tick_in(s.tick),
      .active_in(s.active),
      .count_in(s.blinks),
      .led_out(alarm_led_out)
   );

   // ============================================================
   // Outputs
   assign reg_rdata_out = s.rdata;
   assign fault_indicator_out = ~s.active;
   assign motor_stop_out = s.active;
   assign brake_engage_out = s.active & s.cuts & brake_fitted_in;
   assign ready_out = s.ready;
   assign limit_reached_out = s.limit;
   assign zero_near_out = s.zero_near;
   assign position_readout_clock_out = s.pos_clk;
   assign irq_out = |(s.int_stat & s.int_mask);

   // ============================================================
   // Checks
   AST_FAULT_OFF: assert property (@(posedge core_clk_in) disable iff (srst_in)
      alarm_set_in && !s.active |=> !fault_indicator_out && motor_stop_out)
      else $error("Alarm did not drop fault output");
   AST_CODE_ROUTE: assert property (@(posedge core_clk_in) disable iff (srst_in)
      s.code_en && !prio && s.active |=> {zero_near_out, limit_reached_out, ready_out} == $past(s.blinks))
      else $error("Code bits not on shared outputs");
   AST_PRIO_PASS: assert property (@(posedge core_clk_in) disable iff (srst_in)
      prio |=> ready_out == $past(ready_in) && limit_reached_out == $past(limit_in) &&
               zero_near_out == $past(zero_near_in))
      else $error("Position readout lost priority");
   AST_PRIO_NO_CODE: assert property (@(posedge core_clk_in) disable iff (srst_in)
      prio && s.active && !ready_in && !limit_in && !zero_near_in |=>
         {zero_near_out, limit_reached_out, ready_out} == 3'h0)
      else $error("Code leaked during position readout");
   AST_PRIO_NO_RESET: assert property (@(posedge core_clk_in) disable iff (srst_in)
      s.active && prio && s.mf_prev && !shared_multifunction_in && !cmd_reset |=> s.active)
      else $error("Reset taken through readout clock");
   AST_RISE_KEEPS: assert property (@(posedge core_clk_in) disable iff (srst_in)
      s.active && mf_rise && !cmd_reset |=> s.active)
      else $error("Alarm cleared on rising edge");
   AST_FALL_CLEARS: assert property (@(posedge core_clk_in) disable iff (srst_in)
      s.active && s.resettable && !s.abs_loss && mf_fall && !alarm_set_in |=> !s.active && fault_indicator_out)
      else $error("Falling edge did not clear alarm");
   AST_CMD_CLEARS: assert property (@(posedge core_clk_in) disable iff (srst_in)
      s.active && s.resettable && !s.abs_loss && cmd_reset && !alarm_set_in |=> !s.active)
      else $error("Reset command did not clear alarm");
   AST_NONRES: assert property (@(posedge core_clk_in) disable iff (srst_in)
      s.active && !s.resettable |=> s.active && $stable(s.code))
      else $error("Non-resettable alarm cleared");
   AST_ABS_HOLD: assert property (@(posedge core_clk_in) disable iff (srst_in)
      s.active && s.abs_loss && !s.abs_armed |=> s.active)
      else $error("Position-loss alarm cleared unarmed");
   AST_BRAKE: assert property (@(posedge core_clk_in) disable iff (srst_in)
      alarm_set_in && !s.active && alarm_cuts_current_in && brake_fitted_in |=> brake_engage_out)
      else $error("Brake not engaged");
   AST_HOLD: assert property (@(posedge core_clk_in) disable iff (srst_in)
      s.active && !clear_ok |=> s.active && s.code == $past(s.code) && s.blinks == $past(s.blinks))
      else $error("Alarm changed before a clear");
endmodule

/* testbench/sah_host_model.sv */
// Purpose: Host controller model driving the shared discrete inputs
// Assumes: Actions are called from the bench, one at a time
// Notes: Pulse length is the caller's choice, at least one cycle
`timescale 1ns/1ps
module sah_host_model (
   // Clock
   input wire logic core_clk_in,
   // Host outputs
   output logic shared_multifunction_out,
   output logic position_request_out
);
   initial begin
      shared_multifunction_out = 1'b0;
      position_request_out = 1'b0;
   end
   // ============================================================
   // Host actions
   task automatic drive_mf(input logic v);
      @(posedge core_clk_in);
      shared_multifunction_out <= v;
   endtask
   // ON then OFF; the device acts on the OFF edge
   task automatic clear_pulse(input int n);
      drive_mf(1'b1);
      repeat (n - 1) @(posedge core_clk_in);
      drive_mf(1'b0);
   endtask
   task automatic set_request(input logic v);
      @(posedge core_clk_in);
      position_request_out <= v;
   endtask
endmodule

/* testbench/tb_top.sv */
// Purpose: Self-checking bench of the alarm handler
// Assumes: Short tick and blink counts keep the run brief
// Notes: Shared outputs idle as ready 1, limit 0, zero 1
`timescale 1ns/1ps
`include "sah_defines.svh"
module tb_top;
   logic core_clk_in = 1'b0;
   logic srst_in = 1'b1;
   logic [7:0] reg_addr_in = 8'h00;
   logic [31:0] reg_wdata_in = 32'h0000_0000;
   logic reg_wr_in = 1'b0;
   logic reg_rd_in = 1'b0;
   logic [31:0] reg_rdata_out;
   logic alarm_set_in = 1'b0;
   logic [7:0] alarm_code_in = 8'h00;
   logic [2:0] alarm_blinks_in = 3'h0;
   logic res_in = 1'b0;
   logic abs_in = 1'b0;
   logic cuts_in = 1'b0;
   logic rdy_in = 1'b1, lim_in = 1'b0, zn_in = 1'b1, fitted = 1'b1;
   logic mf;
   logic preq;
   logic fault, stop, brake, rdy, lim, zn, pclk, led, irq, led_q;
   int miscompares = 0;
   int compares = 0;
   int led_rises = 0;
   always #5 core_clk_in = ~core_clk_in;
   always @(posedge core_clk_in) begin
      led_q <= led;
      if (led && !led_q) led_rises++;
   end
   sah_host_model host (.core_clk_in(core_clk_in), .shared_multifunction_out(mf), .position_request_out(preq));
   sah_alarm_handler #(.TICK_CYCLES(4), .BLINK_ON_TICKS(2), .BLINK_OFF_TICKS(2), .BLINK_GAP_TICKS(4)) dut (
      .core_clk_in(core_clk_in), .srst_in(srst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
      .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .alarm_set_in(alarm_set_in),
      .alarm_code_in(alarm_code_in), .alarm_blinks_in(alarm_blinks_in), .alarm_resettable_in(res_in),
      .alarm_abs_loss_in(abs_in), .alarm_cuts_current_in(cuts_in), .position_request_in(preq),
      .shared_multifunction_in(mf), .ready_in(rdy_in), .limit_in(lim_in), .zero_near_in(zn_in),
      .brake_fitted_in(fitted), .fault_indicator_out(fault), .motor_stop_out(stop), .brake_engage_out(brake),
      .ready_out(rdy), .limit_reached_out(lim), .zero_near_out(zn), .position_readout_clock_out(pclk),
      .alarm_led_out(led), .irq_out(irq));
   // ============================================================
   // Access and compare tasks
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_in);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge core_clk_in);
      reg_wr_in <= 1'b0;
   endtask
   task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
      @(posedge core_clk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge core_clk_in);
      reg_rd_in <= 1'b0;
      #1;
      compares++;
      if (reg_rdata_out !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, reg_rdata_out, exp);
      end
   endtask
   task automatic chk_pin(input logic [2:0] got, input logic [2:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_cnt(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic raise(input logic [7:0] c, input logic [2:0] b, input logic r, input logic ab, input logic cu);
      @(posedge core_clk_in);
      alarm_set_in <= 1'b1;
      alarm_code_in <= c;
      alarm_blinks_in <= b;
      res_in <= r;
      abs_in <= ab;
      cuts_in <= cu;
      @(posedge core_clk_in);
      alarm_set_in <= 1'b0;
      tick(1);
   endtask
   task automatic power_cycle();
      @(posedge core_clk_in);
      srst_in <= 1'b1;
      repeat (3) @(posedge core_clk_in);
      srst_in <= 1'b0;
      tick(1);
   endtask
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // ============================================================
   // Tests
   initial begin
      repeat (3) @(posedge core_clk_in);
      srst_in <= 1'b0;
      tick(1);
      chk_pin({fault, stop, brake}, 3'b100);
      chk_reg(`SAH_ADDR_CTRL, 32'h0000_0000);
      chk_reg(8'h40, 32'h0000_0000);
      $display("Test reset done");
      wr(`SAH_ADDR_CTRL, 32'h0000_0001);
      wr(`SAH_ADDR_INT_MASK, 32'h0000_0001);
      raise(8'h2a, 3'h3, 1'b1, 1'b0, 1'b1);
      chk_pin({fault, stop, brake}, 3'b011);
      chk_pin({zn, lim, rdy}, 3'b011);
      chk_pin({2'b00, irq}, 3'b001);
      @(posedge core_clk_in);
      fitted <= 1'b0;
      tick(1);
      chk_pin({fault, stop, brake}, 3'b010);
      @(posedge core_clk_in);
      fitted <= 1'b1;
      tick(48);
      // Three blinks per burst; the next burst lights the LED three cycles after this point
      chk_cnt(led_rises, 32'h0000_0003);
      chk_reg(`SAH_ADDR_STATUS, {8'h00, 8'h2a, 5'h00, 3'h3, 8'h13});
      raise(8'h55, 3'h5, 1'b0, 1'b0, 1'b0);
      chk_reg(`SAH_ADDR_HIST_CNT, 32'h0000_0001);
      chk_reg(`SAH_ADDR_HIST_BASE, 32'h0000_002a);
      chk_pin({zn, lim, rdy}, 3'b011);
      wr(`SAH_ADDR_INT_STAT, 32'h0000_0001);
      tick(1);
      chk_pin({2'b00, irq}, 3'b000);
      $display("Test alarm done");
      host.drive_mf(1'b1);
      tick(3);
      chk_pin({fault, stop, 1'b0}, 3'b010);
      host.drive_mf(1'b0);
      tick(1);
      chk_pin({fault, stop, 1'b0}, 3'b100);
      chk_reg(`SAH_ADDR_INT_STAT, 32'h0000_0002);
      $display("Test reset input done");
      raise(8'h16, 3'h5, 1'b0, 1'b0, 1'b0);
      host.clear_pulse(2);
      wr(`SAH_ADDR_CMD, 32'h0000_0001);
      tick(2);
      chk_pin({fault, stop, 1'b0}, 3'b010);
      power_cycle();
      chk_pin({fault, stop, 1'b0}, 3'b100);
      chk_reg(`SAH_ADDR_HIST_CNT, 32'h0000_0000);
      raise(8'h22, 3'h4, 1'b1, 1'b0, 1'b0);
      wr(`SAH_ADDR_CMD, 32'h0000_0001);
      tick(1);
      chk_pin({fault, stop, 1'b0}, 3'b100);
      $display("Test resettable classes done");
      raise(8'h41, 3'h2, 1'b1, 1'b1, 1'b0);
      host.clear_pulse(2);
      tick(2);
      chk_pin({fault, stop, 1'b0}, 3'b010);
      wr(`SAH_ADDR_CMD, 32'h0000_0004);
      host.clear_pulse(2);
      tick(2);
      chk_pin({fault, stop, 1'b0}, 3'b100);
      $display("Test position loss done");
      wr(`SAH_ADDR_CTRL, 32'h0000_0003);
      host.set_request(1'b1);
      raise(8'h10, 3'h4, 1'b1, 1'b0, 1'b0);
      chk_pin({zn, lim, rdy}, 3'b101);
      @(posedge core_clk_in);
      {zn_in, lim_in, rdy_in} <= 3'b000;
      tick(2);
      chk_pin({zn, lim, rdy}, 3'b000);
      host.drive_mf(1'b1);
      tick(1);
      chk_pin({2'b00, pclk}, 3'b001);
      host.drive_mf(1'b0);
      tick(2);
      chk_pin({fault, stop, pclk}, 3'b010);
      host.set_request(1'b0);
      tick(2);
      chk_pin({zn, lim, rdy}, 3'b100);
      wr(`SAH_ADDR_CMD, 32'h0000_0001);
      $display("Test position priority done");
      wr(`SAH_ADDR_CMD, 32'h0000_0002);
      chk_reg(`SAH_ADDR_HIST_CNT, 32'h0000_0000);
      for (int i = 1; i <= 11; i++) begin
         raise(8'(i), 3'h1, 1'b1, 1'b0, 1'b0);
         wr(`SAH_ADDR_CMD, 32'h0000_0001);
      end
      chk_reg(`SAH_ADDR_HIST_CNT, 32'h0000_000a);
      chk_reg(`SAH_ADDR_HIST_BASE, 32'h0000_000b);
      chk_reg(`SAH_ADDR_HIST_BASE + 8'h24, 32'h0000_0002);
      $display("Test history done");
      close_out();
   end
endmodule
